// ===== ptc_classifier.sv
// packet traffic classifier top with avalon register slave
// Functional notes
// RQ1: each class compares only header bits whose compare enable is set, the rest are ignored.
// RQ2: a class host select of 0 sends matches to the wan path, 1 sends them to the host.
// RQ3: the two-bit host queue field picks the host dma queue, ignored for wan classes.
// RQ4: wan classes take the context descriptor at a per-class byte offset (18 for vlan).
// RQ5: software programs an offset of 42 for an ipv4 udp wan class.
// RQ6: the context offset has no effect for host classes and no descriptor is reported.
// RQ7: in promiscuous mode software includes the destination mac in every pattern.
// RQ8: software matches the ip flags on 0b010 for an ipv4 udp wan class.
// RQ9: software enables destination ip compare for an ip wan class.
// RQ10: software enables vlan tag and udp port compare for wan classes; the bench enables neither for class 0 or class 1.
// RQ11: software matches a dedicated ethertype for a raw vlan wan class.
// RQ12: software enables destination ip compare for a host-bound ipv4 class.
// RQ13: four masked compares run in parallel over the first 64 header bytes.
// RQ14: packets matching no class go to the host on queue 0.
// RQ15: the context descriptor is a two-byte field, first byte most significant.
// RQ16: when several classes match, the lowest-numbered class wins.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module ptc_classifier #(
  parameter int FIFO_DEPTH = ptc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // receive byte stream from the mac
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  // classification result
  output logic             res_valid,
  input  wire logic        res_ready,
  output logic             res_hit,
  output logic [1:0]       res_class,
  output logic             res_to_wan,
  output logic [1:0]       res_queue,
  output logic [15:0]      res_context
);
  localparam int NC = ptc_pkg::NUM_CLASS;
  localparam int NW = NC * ptc_pkg::WORDS_PER_CLS;

  typedef enum logic [1:0] {ST_RUN, ST_EVAL, ST_HOLD} ptc_state_t;
  ptc_state_t state;
  ptc_state_t next_state;

  logic [31:0] pat_mem  [0:NW-1];
  logic [31:0] cmp_mem  [0:NW-1];
  logic [31:0] class_ctrl [0:NC-1];
  logic [31:0] pkt_count;
  logic [6:0]  byte_idx;
  logic        rd_ack;

  // fifo in the receive path; stalls the mac when the result is not taken
  logic       q_valid;
  logic       q_ready;
  logic [8:0] q_data;

  ptc_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   ({rx_last, rx_data}),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  assign q_ready = (state == ST_RUN);
  wire byte_take = q_valid & q_ready;
  wire byte_last = q_data[8];

  // per-class compare engines
  logic [NC-1:0] cls_miss;
  logic [15:0]   cls_ctx [0:NC-1];
  logic [NC-1:0] cls_en;
  logic [NC-1:0] cls_host;
  logic [1:0]    cls_queue [0:NC-1];

  wire [3:0] word_sel = byte_idx[5:2];
  wire [4:0] lane_lsb = {byte_idx[1:0], 3'b000};

  for (genvar c = 0; c < NC; c++) begin : g_cls
    wire [5:0] widx  = {2'(c), word_sel};
    wire [7:0] pat_b = 8'(pat_mem[widx] >> lane_lsb);
    wire [7:0] cmp_b = 8'(cmp_mem[widx] >> lane_lsb);
    assign cls_en[c]    = class_ctrl[c][ptc_pkg::CTRL_EN_BIT];
    assign cls_host[c]  = class_ctrl[c][ptc_pkg::CTRL_HOST_BIT];
    assign cls_queue[c] = class_ctrl[c][ptc_pkg::CTRL_QUEUE_LSB +: 2];

    ptc_class_match u_match (
      .core_clk           (core_clk),
      .rst_n              (rst_n),
      .byte_take          (byte_take),
      .byte_idx           (byte_idx),
      .byte_data          (q_data[7:0]),
      .pat_byte           (pat_b),
      .cmp_byte           (cmp_b),
      .ctx_offset         (class_ctrl[c][ptc_pkg::CTRL_OFS_LSB +: 6]),
      .miss               (cls_miss[c]),
      .context_descriptor (cls_ctx[c])
    );
  end

  // lowest numbered enabled class that saw no miss
  wire [NC-1:0] cls_hit = cls_en & ~cls_miss;
  logic [1:0]   win_cls;
  always_comb begin
    win_cls = 2'd0;
    for (int c = NC - 1; c >= 0; c--) begin
      if (cls_hit[c])
        win_cls = 2'(c); // [RQ16]
    end
  end
  wire any_hit  = |cls_hit;
  wire win_host = cls_host[win_cls];
  wire win_wan  = any_hit & ~win_host; // [RQ2]
  wire [1:0] win_queue = !any_hit ? ptc_pkg::MISS_QUEUE : // [RQ14]
                         win_host ? cls_queue[win_cls] : 2'd0; // [RQ3]
  wire [15:0] win_ctx = win_wan ? cls_ctx[win_cls] : 16'h0000; // [RQ6]

  // packet sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN:  if (byte_take && byte_last) next_state = ST_EVAL;
      ST_EVAL: next_state = ST_HOLD;
      ST_HOLD: if (res_ready) next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state    <= ST_RUN;
      byte_idx <= 7'd0;
    end else begin
      state <= next_state;
      if (byte_take)
        byte_idx <= byte_last ? 7'd0 : (byte_idx == 7'd127 ? byte_idx : byte_idx + 7'd1);
    end
  end

  assign res_valid = (state == ST_HOLD);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      res_hit     <= 1'b0;
      res_class   <= 2'd0;
      res_to_wan  <= 1'b0;
      res_queue   <= 2'd0;
      res_context <= 16'h0000;
      pkt_count   <= 32'h0000_0000;
    end else if (state == ST_EVAL) begin
      res_hit     <= any_hit;
      res_class   <= win_cls;
      res_to_wan  <= win_wan;
      res_queue   <= win_queue;
      res_context <= win_ctx;
      pkt_count   <= pkt_count + 32'h0000_0001;
    end
  end

  // register decode
  wire       sel_pat  = (avs_address[9:8] == ptc_pkg::PAT_BASE[9:8]);
  wire       sel_cmp  = (avs_address[9:8] == ptc_pkg::MASK_BASE[9:8]);
  wire       sel_ctrl = (avs_address[9:4] == ptc_pkg::CTRL_BASE[9:4]);
  wire       sel_stat = (avs_address == ptc_pkg::STAT_ADDR);
  wire       sel_cnt  = (avs_address == ptc_pkg::COUNT_ADDR);
  wire [5:0] mem_idx  = avs_address[7:2];
  wire [1:0] ctrl_idx = avs_address[3:2];
  wire       wr_stb   = avs_write & ~avs_read;

  wire [31:0] stat_word =
    (32'(res_hit)     << ptc_pkg::STAT_HIT_BIT)   |
    (32'(res_class)   << ptc_pkg::STAT_CLS_LSB)   |
    (32'(res_to_wan)  << ptc_pkg::STAT_WAN_BIT)   |
    (32'(res_queue)   << ptc_pkg::STAT_QUEUE_LSB) |
    (32'(res_context) << ptc_pkg::STAT_CTX_LSB);

  wire [31:0] rd_mux = sel_pat  ? pat_mem[mem_idx] :
                       sel_cmp  ? cmp_mem[mem_idx] :
                       sel_ctrl ? class_ctrl[ctrl_idx] :
                       sel_stat ? stat_word :
                       sel_cnt  ? pkt_count : 32'h0000_0000;

  // reads take one wait cycle so read data comes from a flop
  assign avs_waitrequest = avs_read & ~rd_ack;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_ack       <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read & ~rd_ack;
      if (avs_read && !rd_ack)
        avs_readdata <= rd_mux;
    end
  end

  // pattern memories are cleared so an enabled class starts as match-all
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NW; i++) begin
        pat_mem[i] <= 32'h0000_0000;
        cmp_mem[i] <= 32'h0000_0000;
      end
      for (int c = 0; c < NC; c++)
        class_ctrl[c] <= ptc_pkg::CTRL_RESET;
    end else if (wr_stb) begin
      if (sel_pat)
        pat_mem[mem_idx] <= avs_writedata;
      if (sel_cmp)
        cmp_mem[mem_idx] <= avs_writedata;
      if (sel_ctrl)
        class_ctrl[ctrl_idx] <= avs_writedata & 32'h0000_3f0f;
    end
  end
endmodule : ptc_classifier

// ===== ptc_pkg.sv
// constants for the packet traffic classifier
package ptc_pkg;
  localparam int NUM_CLASS      = 4;
  localparam int HDR_BYTES      = 64;
  localparam int WORDS_PER_CLS  = HDR_BYTES / 4;
  localparam int FIFO_DEPTH     = 16;
  // avalon byte addresses
  localparam logic [9:0] PAT_BASE   = 10'h000;
  localparam logic [9:0] MASK_BASE  = 10'h100;
  localparam logic [9:0] CTRL_BASE  = 10'h200;
  localparam logic [9:0] STAT_ADDR  = 10'h210;
  localparam logic [9:0] COUNT_ADDR = 10'h214;
  // class control fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_HOST_BIT  = 1;
  localparam int CTRL_QUEUE_LSB = 2;
  localparam int CTRL_OFS_LSB   = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status fields
  localparam int STAT_HIT_BIT   = 0;
  localparam int STAT_CLS_LSB   = 1;
  localparam int STAT_WAN_BIT   = 3;
  localparam int STAT_QUEUE_LSB = 4;
  localparam int STAT_CTX_LSB   = 16;
  // default destination for unmatched traffic
  localparam logic [1:0] MISS_QUEUE = 2'h0;
endpackage : ptc_pkg

// ===== ptc_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module ptc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ptc_fifo

// ===== ptc_class_match.sv
// one traffic class: masked compare and context capture
`timescale 1ns/1ps
module ptc_class_match (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // byte stream
  input  wire logic        byte_take,
  input  wire logic [6:0]  byte_idx,
  input  wire logic [7:0]  byte_data,
  // class programming
  input  wire logic [7:0]  pat_byte,
  input  wire logic [7:0]  cmp_byte,
  input  wire logic [5:0]  ctx_offset,
  // result
  output logic             miss,
  output logic [15:0]      context_descriptor
);
  wire       in_hdr = (byte_idx < 7'd64);
  wire       first  = (byte_idx == 7'd0);
  // only bits whose compare enable is set can cause a miss
  wire       bad    = in_hdr & |((byte_data ^ pat_byte) & cmp_byte); // [RQ1]
  wire [6:0] ofs    = {1'b0, ctx_offset};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      miss               <= 1'b0;
      context_descriptor <= 16'h0000;
    end else if (byte_take) begin
      miss <= first ? bad : (miss | bad); // [RQ13]
      if (byte_idx == ofs)
        context_descriptor[15:8] <= byte_data; // [RQ4] [RQ15]
      if (byte_idx == ofs + 7'd1)
        context_descriptor[7:0] <= byte_data; // [RQ15]
    end
  end
endmodule : ptc_class_match

// ===== ptc_classifier_chk.sv
// port-level assertions for the classifier top
`timescale 1ns/1ps
module ptc_classifier_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // result
  input wire logic        res_valid,
  input wire logic        res_ready,
  input wire logic        res_hit,
  input wire logic [1:0]  res_class,
  input wire logic        res_to_wan,
  input wire logic [1:0]  res_queue,
  input wire logic [15:0] res_context
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wr_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  rd_late_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer not one cycle late");
  gap_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 10'h214
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  ctrl_rsv_a: assert property (avs_read && !avs_waitrequest && avs_address[9:4] == 6'h20
    |-> avs_readdata[31:14] == 18'h0 && avs_readdata[7:4] == 4'h0)
    else $error("spare control bits not zero");
  res_hold_a: assert property (res_valid && !res_ready |=> res_valid
    && $stable({res_hit, res_class, res_to_wan, res_queue, res_context}))
    else $error("result moved while held");
  res_done_a: assert property (res_valid && res_ready |=> !res_valid)
    else $error("result not released");
  miss_q0_a: assert property (res_valid && !res_hit |-> res_queue == 2'h0 &&
    !res_to_wan && res_class == 2'h0) else $error("miss not on queue 0");
  host_ctx_a: assert property (res_valid && !res_to_wan |-> res_context == 16'h0)
    else $error("host result carries context");
  wan_q0_a: assert property (res_valid && res_to_wan |-> res_hit && res_queue == 2'h0)
    else $error("wan result with queue");
endmodule : ptc_classifier_chk

// ===== ptc_mac_model.sv
// receive mac model feeding 64-byte packets
`timescale 1ns/1ps
module ptc_mac_model (
  // clock
  input  wire logic core_clk,
  // byte stream
  input  wire logic rx_ready,
  output logic      rx_valid,
  output logic [7:0] rx_data,
  output logic      rx_last
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
  end
  // byte i carries i, except byte 12 (class select) and byte 20 (flags 0b010)
  task automatic send(input logic [7:0] b12);
    @(posedge core_clk);
    for (int i = 0; i < 64; i++) begin
      rx_valid <= 1'b1;
      rx_data  <= (i == 12) ? b12 : (i == 20) ? 8'h40 : 8'(i);
      rx_last  <= (i == 63);
      // held until the rising edge that sees ready high takes the byte
      for (int k = 0; k < 300; k++) begin
        @(posedge core_clk);
        if (rx_ready === 1'b1) break;
        if (k == 299) tb.timeout();
      end
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    // released line shows the inverse, never a stale byte
    rx_data  <= ~rx_data;
  endtask : send
endmodule : ptc_mac_model

// ===== tb.sv
// self-checking bench for the classifier
`timescale 1ns/1ps
module tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_valid;
  logic        rx_ready;
  logic        rx_last;
  logic [7:0]  rx_data;
  logic        res_valid;
  logic        res_ready = 1'b0;
  logic        res_hit;
  logic        res_to_wan;
  logic [1:0]  res_class;
  logic [1:0]  res_queue;
  logic [15:0] res_context;
  logic [31:0] rd;
  int          mismatches = 0;
  int          check_count = 0;
  int          refusals = 0;
  ptc_classifier #(.FIFO_DEPTH(ptc_pkg::FIFO_DEPTH)) uut (.core_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_valid,
    .rx_ready, .rx_data, .rx_last, .res_valid, .res_ready, .res_hit, .res_class,
    .res_to_wan, .res_queue, .res_context);
  ptc_mac_model mac (.core_clk, .rx_ready, .rx_valid, .rx_data, .rx_last);
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) if (rx_valid === 1'b1 && rx_ready === 1'b0) refusals++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic timeout;
    mismatches++;
    wrap_up();
  endtask : timeout
  // sample waitrequest at each rising edge; the edge that sees it low accepts
  task automatic hs;
    for (int k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
      if (k == 19) timeout();
    end
    rd = avs_readdata;
  endtask : hs
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    hs();
    avs_write     <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    hs();
    avs_read    <= 1'b0;
    chk(rd, exp);
  endtask : rdc
  task automatic res(input logic [21:0] exp, input int hold);
    for (int k = 0; k < 600; k++) begin
      @(negedge core_clk);
      if (res_valid === 1'b1) break;
      if (k == 599) timeout();
    end
    repeat (hold) @(negedge core_clk);
    chk({res_hit, res_class, res_to_wan, res_queue, res_context}, 32'(exp));
    @(posedge core_clk);
    res_ready <= 1'b1;
    @(posedge core_clk);
    res_ready <= 1'b0;
  endtask : res
  task automatic t_regs;
    rdc(10'h200, ptc_pkg::CTRL_RESET);
    rdc(10'h3fc, 32'h0);
    wr(10'h20c, 32'hffff_ffff);
    rdc(10'h20c, 32'h0000_3f0f);
    wr(10'h20c, 32'h0);
  endtask : t_regs
  task automatic t_cfg;
    wr(10'h00c, 32'hffff_ff81);
    wr(10'h10c, 32'h0000_00ff);
    wr(10'h200, 32'h0000_1201);
    wr(10'h04c, 32'h0000_0008);
    wr(10'h14c, 32'h0000_00ff);
    wr(10'h204, 32'h0000_2a01);
    wr(10'h08c, 32'h0000_0008);
    wr(10'h18c, 32'h0000_00ff);
    wr(10'h09c, 32'hff1e_ffff);
    wr(10'h19c, 32'h00ff_0000);
    wr(10'h208, 32'h0000_120b);
    // destination mac bytes 0..5 in every used class
    for (int c = 0; c < 3; c++) begin
      wr(10'(c * 64), 32'h0302_0100);
      wr(10'(c * 64 + 4), 32'h0000_0504);
      wr(10'(c * 64 + 256), 32'hffff_ffff);
      wr(10'(c * 64 + 260), 32'h0000_ffff);
    end
    // udp class: flags in the top three bits of byte 20
    wr(10'h054, 32'h0000_0040);
    wr(10'h154, 32'h0000_00e0);
    // udp class: destination address in bytes 30..33
    wr(10'h05c, 32'h1f1e_0000);
    wr(10'h15c, 32'hffff_0000);
    wr(10'h060, 32'h0000_2120);
    wr(10'h160, 32'h0000_ffff);
  endtask : t_cfg
  task automatic t_wan;
    mac.send(8'h81);
    res({1'b1, 2'h0, 1'b1, 2'h0, 16'h1213}, 0);
    rdc(ptc_pkg::STAT_ADDR, 32'h1213_0009);
  endtask : t_wan
  task automatic t_prio;
    mac.send(8'h08);
    res({1'b1, 2'h1, 1'b1, 2'h0, 16'h2a2b}, 0);
  endtask : t_prio
  task automatic t_host;
    wr(10'h204, 32'h0);
    mac.send(8'h08);
    res({1'b1, 2'h2, 1'b0, 2'h2, 16'h0}, 0);
  endtask : t_host
  // long hold on the miss lets the next packet fill the fifo
  task automatic t_miss_stall;
    fork
      begin
        mac.send(8'h55);
        mac.send(8'h81);
      end
      begin
        res(22'h0, 40);
        res({1'b1, 2'h0, 1'b1, 2'h0, 16'h1213}, 0);
      end
    join
    chk(32'(refusals > 0), 32'h1);
    rdc(ptc_pkg::COUNT_ADDR, 32'h5);
  endtask : t_miss_stall
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_cfg();
    t_wan();
    t_prio();
    t_host();
    t_miss_stall();
    wrap_up();
  end
endmodule : tb
bind ptc_classifier ptc_classifier_chk chk (.core_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .res_valid, .res_ready, .res_hit,
  .res_class, .res_to_wan, .res_queue, .res_context);
